// >>> hw/reader_regs.svh
/*
 * register offsets, field positions, reset values and timing figures of the
 * reader status and read gate block.
 * assumes a byte-addressed plain register port, 8-bit address, 32-bit data.
 */
`ifndef READER_REGS_SVH
`define READER_REGS_SVH

`define RG_CTRL_OFS 8'h00
`define RG_NET_OFS 8'h04
`define RG_CMD_OFS 8'h08
`define RG_STATUS_OFS 8'h0c
`define RG_PULSE_OFS 8'h10
`define RG_CODE_OFS 8'h14
`define RG_SCAN_OFS 8'h18
`define RG_GOOD_OFS 8'h1c

`define CTRL_SERVICE 0
`define CTRL_WARNING 1
`define CTRL_ERROR 2
`define CTRL_SELFTEST 3
`define CTRL_SRC_LO 4
`define CTRL_SRC_HI 5
`define CTRL_DIR_LO 6
`define CTRL_DIR_HI 7
`define CTRL_OUTVAL_LO 8
`define CTRL_OUTVAL_HI 9
`define CTRL_OUTSEL_LO 10
`define CTRL_OUTSEL_HI 11

`define NET_IP_OK 0
`define NET_PROTO_OK 1
`define NET_MASTER_OK 2
`define NET_TIMEOUT 3
`define NET_DUP_IP 4

`define CMD_OPEN 0
`define CMD_CLOSE 1

`define CODE_I25_MAX_LO 16
`define CODE_I25_MAX_HI 23
`define CODE_I25 4'h0

`define CTRL_RESET 12'h000
`define NET_RESET 5'h00
`define PULSE_RESET 16'h0064
`define CODE_EN_RESET 16'hffff
`define I25_MAX_RESET 8'h0a

`define CLK_HZ 10000000
`define SCAN_PER_S 1000
`define SCAN_PERIOD_US 1000
`define MS_CYCLES (`SCAN_PERIOD_US * (`CLK_HZ / 1000000))
`define FLASH_HALF_MS 500
`define STARTUP_STEP_MS 1000

`endif

// >>> hw/reader_pkg.sv
/*
 * types shared by the reader status and read gate block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package reader_pkg;
  typedef enum logic [1:0] {DISP_STARTUP, DISP_DESIGNATION, DISP_RESULT} display_e;
  typedef enum logic [1:0] {SRC_SWITCH, SRC_HOST, SRC_REFLECTOR} gate_src_e;
  typedef enum logic [1:0] {IND_NONE, IND_BLANK_GOOD, IND_BLANK_BAD, IND_RED_BAD} ind_e;
endpackage

// >>> hw/bit_sync.sv
/*
 * two-stage synchroniser, one lane per bit.
 * assumes asynchronous inputs; the first stage feeds only the second.
 */
`timescale 1ns/1ns
module bit_sync #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;
  sync_s s_reg;
  sync_s s_next;

  always_comb begin
    s_next = s_reg;
    if (ce) begin
      s_next.meta = din;
      s_next.stable = s_reg.meta;
    end
  end

  // one register process keeps the whole state under a single driver
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.stable;
endmodule

// >>> hw/tick_divider.sv
/*
 * free running divider giving a one-cycle tick every PERIOD enabled cycles.
 * assumes PERIOD of at least one and below 2**W.
 */
`timescale 1ns/1ns
module tick_divider #(
  parameter int PERIOD = 10000,
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } div_s;
  div_s s_reg;
  div_s s_next;

  always_comb begin
    s_next = s_reg;
    if (ce) begin
      s_next.tick = 1'b0;
      if (s_reg.cnt == W'(PERIOD - 1)) begin
        s_next.cnt = '0;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule

// >>> hw/reader_status_gate.sv
/*
 * status lamps, display sequence and reading gate of a bar code reader.
 * assumes a decoder on the same clock reporting each decoded code with a
 * one-cycle strobe, and software on a plain register port holding the device
 * and network conditions.
 */
`timescale 1ns/1ns
`include "reader_regs.svh"
module reader_status_gate
  import reader_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int FLASH_HALF_MS = `FLASH_HALF_MS,
  parameter int STARTUP_STEP_MS = `STARTUP_STEP_MS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [1:0] switchLineIn,
  output logic [1:0] switchLineOut,
  output logic [1:0] switchLineOe,
  input wire logic reflectorBlocked,
  input wire logic codeValid,
  input wire logic [3:0] codeType,
  input wire logic [7:0] codeLen,
  output logic decodeEnable,
  output logic scanTick,
  output logic resultValid,
  output logic [3:0] resultType,
  output logic [7:0] resultLen,
  output logic [1:0] displayScreen,
  output logic powerGreen,
  output logic powerRed,
  output logic netGreen,
  output logic netRed
);
  typedef struct packed {
    logic [11:0] ctrl;
    logic [4:0] net;
    logic [15:0] pulseLen;
    logic [15:0] codeEn;
    logic [7:0] i25Max;
    display_e disp;
    logic [15:0] stepCnt;
    logic [15:0] flashCnt;
    logic flashPh;
    logic gateOpen;
    logic goodSeen;
    ind_e ind;
    logic [15:0] indCnt;
    logic [15:0] scanCnt;
    logic [15:0] goodCnt;
    logic [1:0] swOut;
    logic [1:0] swOe;
    logic scanTick;
    logic resultValid;
    logic [3:0] resultType;
    logic [7:0] resultLen;
    logic [31:0] rdata;
    logic powerGreen;
    logic powerRed;
    logic netGreen;
    logic netRed;
  } state_s;

  state_s s_reg;
  state_s s_next;
  logic [1:0] swSync;
  logic msTick;

  bit_sync #(
    .W(2)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .din(switchLineIn),
    .dout(swSync)
  );

  // one millisecond tick paces scanning, flashing and brief indications
  tick_divider #(
    .PERIOD(MS_CYCLES),
    .W(16)
  ) u_ms (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .tick(msTick)
  );

  always_comb begin
    logic hostOpen;
    logic hostClose;
    logic ready;
    logic want;
    logic accept;
    logic gateFlag;
    logic [1:0] isInput;
    logic [1:0] outVal;
    gate_src_e src;
    hostOpen = 1'b0;
    hostClose = 1'b0;
    ready = 1'b0;
    want = 1'b0;
    accept = 1'b0;
    gateFlag = 1'b0;
    isInput = 2'b00;
    outVal = 2'b00;
    src = SRC_SWITCH;
    s_next = s_reg;

    if (ce) begin
      s_next.resultValid = 1'b0;
      s_next.scanTick = 1'b0;
      s_next.rdata = '0;

      if (wr) begin
        case (addr)
          `RG_CTRL_OFS: begin
            s_next.ctrl = wdata[11:0];
          end
          `RG_NET_OFS: begin
            s_next.net = wdata[4:0];
          end
          `RG_CMD_OFS: begin
            hostOpen = wdata[`CMD_OPEN];
            hostClose = wdata[`CMD_CLOSE];
          end
          `RG_PULSE_OFS: begin
            s_next.pulseLen = wdata[15:0];
          end
          `RG_CODE_OFS: begin
            s_next.codeEn = wdata[15:0];
            s_next.i25Max = wdata[`CODE_I25_MAX_HI:`CODE_I25_MAX_LO];
          end
          default: begin
          end
        endcase
      end

      // display walks startup, designation, result on fixed steps
      if (msTick && s_reg.disp != DISP_RESULT) begin
        if (s_reg.stepCnt == 16'(STARTUP_STEP_MS - 1)) begin
          s_next.stepCnt = '0;
          s_next.disp = (s_reg.disp == DISP_STARTUP) ? DISP_DESIGNATION : DISP_RESULT;
        end else begin
          s_next.stepCnt = s_reg.stepCnt + 16'h0001;
        end
      end
      ready = (s_reg.disp == DISP_RESULT);

      if (msTick) begin
        if (s_reg.flashCnt == 16'(FLASH_HALF_MS - 1)) begin
          s_next.flashCnt = '0;
          s_next.flashPh = ~s_reg.flashPh;
        end else begin
          s_next.flashCnt = s_reg.flashCnt + 16'h0001;
        end
      end

      // gate source select; a line only triggers while set as input
      isInput = ~s_reg.ctrl[`CTRL_DIR_HI:`CTRL_DIR_LO];
      src = gate_src_e'(s_reg.ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO]);
      case (src)
        SRC_SWITCH: begin
          want = |(swSync & isInput);
        end
        SRC_HOST: begin
          want = hostOpen ? 1'b1 : (hostClose ? 1'b0 : s_reg.gateOpen);
        end
        SRC_REFLECTOR: begin
          want = reflectorBlocked;
        end
        default: begin
          want = 1'b0;
        end
      endcase
      // no gate before the device is ready
      want = want & ready;
      s_next.gateOpen = want;

      accept = s_reg.gateOpen & codeValid & s_reg.codeEn[codeType]
        & ~((codeType == `CODE_I25) & (codeLen > s_reg.i25Max));

      if (want && !s_reg.gateOpen) begin
        s_next.goodSeen = 1'b0;
        s_next.scanCnt = '0;
      end

      if (msTick && s_reg.gateOpen) begin
        s_next.scanTick = 1'b1;
        s_next.scanCnt = s_reg.scanCnt + 16'h0001;
      end

      // brief indications count down in milliseconds
      if (msTick && s_reg.ind != IND_NONE) begin
        if (s_reg.indCnt <= 16'h0001) begin
          if (s_reg.ind == IND_BLANK_BAD) begin
            s_next.ind = IND_RED_BAD;
            s_next.indCnt = s_reg.pulseLen;
          end else begin
            s_next.ind = IND_NONE;
          end
        end else begin
          s_next.indCnt = s_reg.indCnt - 16'h0001;
        end
      end

      if (accept) begin
        s_next.resultValid = 1'b1;
        s_next.resultType = codeType;
        s_next.resultLen = codeLen;
        s_next.goodSeen = 1'b1;
        s_next.goodCnt = s_reg.goodCnt + 16'h0001;
        s_next.ind = IND_BLANK_GOOD;
        s_next.indCnt = s_reg.pulseLen;
      end else if (!want && s_reg.gateOpen && !s_reg.goodSeen) begin
        // gate closed with nothing decoded
        s_next.ind = IND_BLANK_BAD;
        s_next.indCnt = s_reg.pulseLen;
      end

      // output lines show a set level or the gate state
      gateFlag = s_reg.gateOpen;
      outVal = s_reg.ctrl[`CTRL_OUTVAL_HI:`CTRL_OUTVAL_LO];
      for (int i = 0; i < 2; i++) begin
        s_next.swOut[i] = s_reg.ctrl[`CTRL_OUTSEL_LO + i] ? gateFlag : outVal[i];
      end
      s_next.swOe = ~isInput;

      // power lamp, error first, then warning, then service, then normal states
      if (s_reg.ctrl[`CTRL_ERROR]) begin
        s_next.powerGreen = 1'b0;
        s_next.powerRed = 1'b1;
      end else if (s_reg.ctrl[`CTRL_WARNING]) begin
        s_next.powerGreen = 1'b0;
        s_next.powerRed = s_reg.flashPh;
      end else if (s_reg.ctrl[`CTRL_SERVICE]) begin
        s_next.powerGreen = 1'b1;
        s_next.powerRed = 1'b1;
      end else if (!ready) begin
        s_next.powerGreen = s_reg.flashPh;
        s_next.powerRed = 1'b0;
      end else begin
        case (s_reg.ind)
          IND_BLANK_GOOD, IND_BLANK_BAD: begin
            s_next.powerGreen = 1'b0;
            s_next.powerRed = 1'b0;
          end
          IND_RED_BAD: begin
            s_next.powerGreen = 1'b0;
            s_next.powerRed = 1'b1;
          end
          default: begin
            s_next.powerGreen = 1'b1;
            s_next.powerRed = 1'b0;
          end
        endcase
      end

      // network lamp
      if (s_reg.ctrl[`CTRL_SELFTEST]) begin
        s_next.netGreen = s_reg.flashPh;
        s_next.netRed = ~s_reg.flashPh;
      end else if (!s_reg.net[`NET_IP_OK]) begin
        s_next.netGreen = 1'b0;
        s_next.netRed = 1'b0;
      end else if (s_reg.net[`NET_DUP_IP]) begin
        s_next.netGreen = 1'b0;
        s_next.netRed = 1'b1;
      end else if (s_reg.net[`NET_TIMEOUT]) begin
        s_next.netGreen = 1'b0;
        s_next.netRed = s_reg.flashPh;
      end else if (!s_reg.net[`NET_PROTO_OK] || !s_reg.net[`NET_MASTER_OK]) begin
        s_next.netGreen = s_reg.flashPh;
        s_next.netRed = 1'b0;
      end else begin
        s_next.netGreen = 1'b1;
        s_next.netRed = 1'b0;
      end

      if (rd) begin
        case (addr)
          `RG_CTRL_OFS: begin
            s_next.rdata = {20'h00000, s_reg.ctrl};
          end
          `RG_NET_OFS: begin
            s_next.rdata = {27'h0000000, s_reg.net};
          end
          `RG_STATUS_OFS: begin
            s_next.rdata = {18'h00000, s_reg.netRed, s_reg.netGreen, s_reg.powerRed, s_reg.powerGreen,
              swSync, s_reg.ind, s_reg.disp, 1'b0, s_reg.goodSeen, ready, s_reg.gateOpen};
          end
          `RG_PULSE_OFS: begin
            s_next.rdata = {16'h0000, s_reg.pulseLen};
          end
          `RG_CODE_OFS: begin
            s_next.rdata = {8'h00, s_reg.i25Max, s_reg.codeEn};
          end
          `RG_SCAN_OFS: begin
            s_next.rdata = {16'h0000, s_reg.scanCnt};
          end
          `RG_GOOD_OFS: begin
            s_next.rdata = {16'h0000, s_reg.goodCnt};
          end
          default: begin
            s_next.rdata = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.ctrl <= `CTRL_RESET;
      s_reg.net <= `NET_RESET;
      s_reg.pulseLen <= `PULSE_RESET;
      s_reg.codeEn <= `CODE_EN_RESET;
      s_reg.i25Max <= `I25_MAX_RESET;
      s_reg.disp <= DISP_STARTUP;
      s_reg.ind <= IND_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign switchLineOut = s_reg.swOut;
  assign switchLineOe = s_reg.swOe;
  assign decodeEnable = s_reg.gateOpen;
  assign scanTick = s_reg.scanTick;
  assign resultValid = s_reg.resultValid;
  assign resultType = s_reg.resultType;
  assign resultLen = s_reg.resultLen;
  assign displayScreen = s_reg.disp;
  assign powerGreen = s_reg.powerGreen;
  assign powerRed = s_reg.powerRed;
  assign netGreen = s_reg.netGreen;
  assign netRed = s_reg.netRed;
endmodule

// >>> bench/reader_status_gate_props.sv
/* port checker of the reader status and read gate block.
   assumes it is bound to the top module; lamp settings are shadowed from writes. */
`timescale 1ns/1ns
module reader_status_gate_props #(
  parameter int MS_CYCLES = 10000
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic codeValid,
  input wire logic [3:0] codeType,
  input wire logic [7:0] codeLen,
  input wire logic decodeEnable,
  input wire logic scanTick,
  input wire logic resultValid,
  input wire logic [3:0] resultType,
  input wire logic [7:0] resultLen,
  input wire logic [1:0] displayScreen,
  input wire logic powerGreen,
  input wire logic powerRed,
  input wire logic netGreen,
  input wire logic netRed
);
  logic [7:0] ctrl_reg, net_reg;
  logic [1:0] quiet_reg;
  logic [15:0] gap_reg;
  logic gapOk_reg;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= 8'h0;
      net_reg <= 8'h0;
      quiet_reg <= 2'h0;
      gap_reg <= 16'h0;
      gapOk_reg <= 1'b0;
    end else begin
      if (wr && addr == 8'h00) ctrl_reg <= wdata[7:0];
      if (wr && addr == 8'h04) net_reg <= wdata[7:0];
      // lamps are registered behind the register, so wait three edges after the write
      if (wr && (addr == 8'h00 || addr == 8'h04)) quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h3) quiet_reg <= quiet_reg + 2'h1;
      gap_reg <= scanTick ? 16'h1 : gap_reg + 16'h1;
      // period only judged between two ticks of one unbroken gate
      gapOk_reg <= decodeEnable && (scanTick || gapOk_reg);
    end
  end
  sequence sSettled;
    quiet_reg == 2'h3 && !ctrl_reg[3];
  endsequence
  sequence sAccept;
    codeValid && decodeEnable && codeLen <= 8'h0a;
  endsequence
  AST_GATE_READY: assert property (decodeEnable |-> displayScreen == 2'h2)
    else $error("gate open before ready");
  AST_DISP_STEP: assert property ($changed(displayScreen) |-> displayScreen == $past(displayScreen) + 2'h1)
    else $error("display skipped a screen");
  AST_RES_GATED: assert property (resultValid |-> $past(codeValid) && $past(decodeEnable))
    else $error("result without open gate");
  AST_RES_FWD: assert property (sAccept |=> resultValid && resultType == $past(codeType) && resultLen == $past(codeLen))
    else $error("code not forwarded");
  AST_I25_CAP: assert property (codeValid && codeType == 4'h0 && codeLen > 8'h0a |=> !resultValid)
    else $error("long interleaved code forwarded");
  AST_SCAN_GATED: assert property (scanTick |-> decodeEnable || $past(decodeEnable))
    else $error("scan outside gate");
  AST_SCAN_RATE: assert property (scanTick && gapOk_reg |-> gap_reg == MS_CYCLES)
    else $error("scan period wrong");
  AST_ERR_RED: assert property (sSettled ##0 ctrl_reg[2] |-> powerRed && !powerGreen)
    else $error("error lamp not steady red");
  AST_SERVICE: assert property (sSettled ##0 ctrl_reg[2:0] == 3'h1 |-> powerRed && powerGreen)
    else $error("service lamp not orange");
  AST_NET_OFF: assert property (sSettled ##0 !net_reg[0] |-> !netGreen && !netRed)
    else $error("net lamp lit without address");
  AST_NET_DUP: assert property (sSettled ##0 net_reg[0] && net_reg[4] |-> netRed && !netGreen)
    else $error("net lamp not red on duplicate");
  AST_NET_OK: assert property (sSettled ##0 net_reg[4:0] == 5'h07 |-> netGreen && !netRed)
    else $error("net lamp not green");
endmodule
bind reader_status_gate reader_status_gate_props #(.MS_CYCLES(MS_CYCLES)) props (
  .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
  .codeValid(codeValid), .codeType(codeType), .codeLen(codeLen),
  .decodeEnable(decodeEnable), .scanTick(scanTick), .resultValid(resultValid),
  .resultType(resultType), .resultLen(resultLen), .displayScreen(displayScreen),
  .powerGreen(powerGreen), .powerRed(powerRed), .netGreen(netGreen), .netRed(netRed)
);

// >>> bench/reader_field_model.sv
/* field side model: trigger lines and decoder strobes.
   assumes the bench calls its tasks from the main sequence. */
`timescale 1ns/1ns
module reader_field_model (
  input wire logic clock,
  input wire logic [1:0] switchLineOut,
  input wire logic [1:0] switchLineOe,
  output logic [1:0] switchLineIn,
  output logic codeValid,
  output logic [3:0] codeType,
  output logic [7:0] codeLen
);
  logic [1:0] drv = 2'h0;
  // a line the reader drives shows its own level
  assign switchLineIn = (switchLineOe & switchLineOut) | (~switchLineOe & drv);
  initial begin
    codeValid = 1'b0;
    codeType = 4'h0;
    codeLen = 8'h0;
  end
  task automatic trig(input int i, input logic v);
    @(posedge clock);
    drv[i] <= v;
  endtask
  task automatic send(input logic [3:0] t, input logic [7:0] l);
    @(posedge clock);
    codeValid <= 1'b1;
    codeType <= t;
    codeLen <= l;
    @(posedge clock);
    codeValid <= 1'b0;
    // stale fields inverted so nothing leans on them
    codeType <= ~t;
    codeLen <= ~l;
  endtask
endmodule

// >>> bench/reader_status_gate_tb.sv
/* self-checking bench of the reader status and read gate block.
   assumes the field model and the bound checker; ms shortened to 4 cycles. */
`timescale 1ns/1ns
module reader_status_gate_tb;
  logic clock, nrst, wr, rd, reflectorBlocked, ce;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] switchLineIn, switchLineOut, switchLineOe, displayScreen;
  logic codeValid, decodeEnable, scanTick, resultValid;
  logic [3:0] codeType, resultType, t;
  logic [7:0] codeLen, resultLen, l;
  logic powerGreen, powerRed, netGreen, netRed;
  int fail_count = 0;
  int compares = 0;
  int goodExp = 0;
  int seed = 77869;
  reader_status_gate #(.MS_CYCLES(4), .FLASH_HALF_MS(3), .STARTUP_STEP_MS(2)) uut (
    .clock(clock), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .switchLineIn(switchLineIn), .switchLineOut(switchLineOut),
    .switchLineOe(switchLineOe), .reflectorBlocked(reflectorBlocked), .codeValid(codeValid),
    .codeType(codeType), .codeLen(codeLen), .decodeEnable(decodeEnable), .scanTick(scanTick),
    .resultValid(resultValid), .resultType(resultType), .resultLen(resultLen),
    .displayScreen(displayScreen), .powerGreen(powerGreen), .powerRed(powerRed),
    .netGreen(netGreen), .netRed(netRed));
  reader_field_model fm (
    .clock(clock), .switchLineOut(switchLineOut), .switchLineOe(switchLineOe),
    .switchLineIn(switchLineIn), .codeValid(codeValid), .codeType(codeType), .codeLen(codeLen));
  task automatic close_out();
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata === e, "read data");
  endtask
  task automatic waitgate(input logic v);
    #1;
    for (int n = 0; n < 12 && decodeEnable !== v; n++) cyc(1);
    chk(decodeEnable === v, "gate state");
  endtask
  task automatic waitlamp(input logic g, input logic r, input int lim);
    #1;
    for (int n = 0; n < lim && {powerGreen, powerRed} !== {g, r}; n++) cyc(1);
    chk({powerGreen, powerRed} === {g, r}, "power lamp");
  endtask
  function automatic logic accept(input logic [3:0] ty, input logic [7:0] ln);
    return !(ty == 4'h0 && ln > 8'h0a);
  endfunction
  task automatic code(input logic [3:0] ty, input logic [7:0] ln, input logic open);
    logic e;
    e = open && accept(ty, ln);
    fm.send(ty, ln);
    #1;
    chk(resultValid === e, "result strobe");
    if (e) begin
      goodExp++;
      chk({resultType, resultLen} === {ty, ln}, "result fields");
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    reflectorBlocked = 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    rchk(8'h10, 32'h64);
    rchk(8'h14, 32'h000affff);
    rchk(8'h20, 32'h0);
    wreg(8'h10, 32'h2);
    #1;
    for (int n = 0; n < 60 && displayScreen !== 2'h2; n++) cyc(1);
    chk(displayScreen === 2'h2, "display");
    code(4'h3, 8'h05, 1'b0);
    fm.trig(0, 1'b1);
    waitgate(1'b1);
    code(4'h0, 8'h0a, 1'b1);
    code(4'h0, 8'h0b, 1'b1);
    for (int i = 0; i < 10; i++) begin
      t = 4'($random(seed));
      l = 8'($random(seed)) & 8'h0f;
      code(t, l, 1'b1);
    end
    code(4'h1, 8'h04, 1'b1);
    waitlamp(1'b0, 1'b0, 8);
    waitlamp(1'b1, 1'b0, 20);
    rchk(8'h1c, 32'(goodExp));
    fm.trig(0, 1'b0);
    waitgate(1'b0);
    wreg(8'h00, 32'h10);
    wreg(8'h08, 32'h1);
    waitgate(1'b1);
    wreg(8'h08, 32'h2);
    waitgate(1'b0);
    waitlamp(1'b0, 1'b0, 8);
    waitlamp(1'b0, 1'b1, 20);
    waitlamp(1'b1, 1'b0, 20);
    wreg(8'h00, 32'h20);
    @(posedge clock);
    reflectorBlocked <= 1'b1;
    waitgate(1'b1);
    code(4'h2, 8'h08, 1'b1);
    @(posedge clock);
    reflectorBlocked <= 1'b0;
    waitgate(1'b0);
    wreg(8'h00, 32'h140);
    cyc(3);
    chk(switchLineOe === 2'h1 && switchLineOut[0] === 1'b1 && decodeEnable === 1'b0, "line drive");
    fm.trig(1, 1'b1);
    waitgate(1'b1);
    fm.trig(1, 1'b0);
    waitgate(1'b0);
    for (int i = 0; i < 32; i++) begin
      wreg(8'h04, 32'(i));
      cyc(4);
      if (i[0] && i[3] && !i[4]) begin
        chk(netGreen === 1'b0, "timeout lamp");
      end
    end
    wreg(8'h04, 32'h7);
    cyc(4);
    chk(netGreen === 1'b1 && netRed === 1'b0, "net lamp");
    for (int i = 0; i < 4; i++) begin
      wreg(8'h00, 32'h1 << i);
      cyc(4);
      if (i == 1) begin
        chk(powerGreen === 1'b0, "warning lamp");
      end
      if (i == 3) begin
        chk((netGreen ^ netRed) === 1'b1, "self test lamp");
      end
    end
    // warning and error together: the error must win
    wreg(8'h00, 32'h6);
    cyc(4);
    chk(powerRed === 1'b1 && powerGreen === 1'b0, "lamp priority");
    @(posedge clock);
    nrst <= 1'b0;
    cyc(2);
    chk(displayScreen === 2'h0 && powerGreen === 1'b0, "reset outputs");
    @(posedge clock);
    nrst <= 1'b1;
    // enable low must hold the startup screen past its usual step time
    ce <= 1'b0;
    cyc(24);
    chk(displayScreen === 2'h0 && decodeEnable === 1'b0, "enable freeze");
    @(posedge clock);
    ce <= 1'b1;
    rchk(8'h00, 32'h0);
    close_out();
  end
endmodule
